// ---- mrs_ctrl.sv ----
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "mrs_ctrl_defs.svh"
module mrs_ctrl
  import mrs_ctrl_pkg::*;
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RESET_IN,
  input  wire logic [3:0]  ADDR_IN,
  input  wire logic [15:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic [15:0]      RDATA_OUT,
  output logic             CS_N_OUT,
  output logic             RAS_N_OUT,
  output logic             CAS_N_OUT,
  output logic             WE_N_OUT,
  output logic             CKE_OUT,
  output logic [1:0]       BA_OUT,
  output logic [13:0]      A_OUT
);
  seq_state_t  state_q;
  logic [13:0] mode_q;
  logic [13:0] ext_q;
  logic [15:0] lock_q;
  logic [3:0]  gap_q;
  logic        busy_q;
  logic        err_q;
  logic        dll_rst_seen_q;
  logic [13:0] col_q;
  logic [2:0]  word_q;
  logic        rd_pend_q;
  logic [13:0] opcode;
  logic [2:0]  start;
  logic [2:0]  blen;

  function automatic logic legal_mode(input logic [15:0] v);
    legal_mode = ((v[6:4] == `RL_2) || (v[6:4] == `RL_2P5)) &&
                 (v[2:0] >= `BLC_2) && (v[2:0] <= `BLC_8);
  endfunction

  function automatic logic [2:0] burst_len(input logic [2:0] c);
    case (c)
      `BLC_2:  burst_len = 3'h1;
      `BLC_4:  burst_len = 3'h3;
      `BLC_8:  burst_len = 3'h7;
      default: burst_len = 3'h1;
    endcase
  endfunction

  assign blen  = burst_len(mode_q[`BL_POS +: 3]);
  assign start = col_q[2:0] & blen;

  // Opcode per state; mode bits above A6 are zero save A8 on reset
  always_comb begin
    opcode = 14'h0000;
    case (state_q)
      ST_EXT:  opcode = ext_q & ~(14'h0001 << `EXT_DLL_DIS_BIT);
      ST_DLLR: opcode = {7'h00, mode_q[6:0]} | (14'h0001 << `DLL_RST_BIT);
      ST_NORM: opcode = {7'h00, mode_q[6:0]};
      default: opcode = 14'h0000;
    endcase
  end

  // Register writes
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      mode_q <= `MODE_RST;
      ext_q  <= `EXT_RST;
      err_q  <= 1'b0;
    end else if (WR_IN && ADDR_IN == `REG_MODE && !busy_q) begin
      if (legal_mode(WDATA_IN)) begin
        mode_q <= {7'h00, WDATA_IN[6:0]};
      end else begin
        err_q <= 1'b1;
      end
    end else if (WR_IN && ADDR_IN == `REG_EXT && !busy_q) begin
      ext_q <= WDATA_IN[13:0];
    end else if (WR_IN && ADDR_IN == `REG_STATUS) begin
      err_q <= 1'b0;
    end
  end

  // Sequencer: ext load, DLL reset, normal load, gap wait
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      state_q <= ST_IDLE;
      gap_q   <= 4'h0;
      lock_q  <= 16'h0000;
      busy_q  <= 1'b0;
      dll_rst_seen_q <= 1'b0;
    end else begin
      if (gap_q != 4'h0) begin
        gap_q <= gap_q - 4'h1;
      end
      if (lock_q != 16'h0000 && CKE_OUT) begin
        lock_q <= lock_q - 16'h0001;
      end
      case (state_q)
        ST_IDLE: begin
          if (WR_IN && ADDR_IN == `REG_CTRL && WDATA_IN[0] && !rd_pend_q) begin
            state_q <= ST_EXT;
            busy_q  <= 1'b1;
          end else if (WR_IN && ADDR_IN == `REG_READ && lock_q == 16'h0000) begin
            state_q <= ST_READ;
          end
        end
        ST_EXT: if (gap_q == 4'h0) begin
          state_q <= ST_DLLR;
          gap_q   <= `MRS_GAP_CYC;
          lock_q  <= `DLL_LOCK_CYC;
        end
        ST_DLLR: if (gap_q == 4'h0) begin
          state_q <= ST_NORM;
          gap_q   <= `MRS_GAP_CYC;
          dll_rst_seen_q <= 1'b1;
        end
        ST_NORM: if (gap_q == 4'h0) begin
          state_q <= ST_WAIT;
          gap_q   <= `MRS_GAP_CYC;
          dll_rst_seen_q <= 1'b0;
        end
        ST_WAIT: if (gap_q == 4'h0) begin
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
        end
        ST_READ: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Read column capture and burst word walk
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      col_q     <= 14'h0000;
      word_q    <= 3'h0;
      rd_pend_q <= 1'b0;
    end else if (state_q == ST_IDLE && WR_IN && ADDR_IN == `REG_READ && lock_q == 16'h0000) begin
      col_q     <= WDATA_IN[13:0] & 14'h0BFF;
      word_q    <= 3'h0;
      rd_pend_q <= 1'b1;
    end else if (rd_pend_q) begin
      word_q <= word_q + 3'h1;
      if ((word_q & blen) == blen) begin
        rd_pend_q <= 1'b0;
      end
    end
  end

  // Pin drive from flops
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      CS_N_OUT  <= 1'b1;
      RAS_N_OUT <= 1'b1;
      CAS_N_OUT <= 1'b1;
      WE_N_OUT  <= 1'b1;
      CKE_OUT   <= 1'b0;
      BA_OUT    <= 2'h0;
      A_OUT     <= 14'h0000;
    end else begin
      CKE_OUT   <= 1'b1;
      CS_N_OUT  <= 1'b1;
      RAS_N_OUT <= 1'b1;
      CAS_N_OUT <= 1'b1;
      WE_N_OUT  <= 1'b1;
      A_OUT     <= 14'h0000;
      BA_OUT    <= 2'h0;
      if ((state_q == ST_EXT || state_q == ST_DLLR || state_q == ST_NORM)
          && gap_q == 4'h0) begin
        CS_N_OUT  <= 1'b0;
        RAS_N_OUT <= 1'b0;
        CAS_N_OUT <= 1'b0;
        WE_N_OUT  <= 1'b0;
        A_OUT     <= opcode;
        BA_OUT    <= (state_q == ST_EXT) ? `BA_EXT : `BA_MODE;
      end else if (state_q == ST_READ) begin
        CS_N_OUT  <= 1'b0;
        CAS_N_OUT <= 1'b0;
        A_OUT     <= {col_q[13:3], col_q[2:0]} & ~14'h0400;
      end
    end
  end

  // Current burst column: sequential add or interleaved xor
  logic [2:0] cur_lo;
  always_comb begin
    if (mode_q[`BT_POS]) begin
      cur_lo = start ^ (word_q & blen);
    end else begin
      cur_lo = (start + (word_q & blen)) & blen;
    end
  end

  // Register reads, data one cycle later
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      RDATA_OUT <= 16'h0000;
    end else if (RD_IN) begin
      case (ADDR_IN)
        `REG_MODE:   RDATA_OUT <= {2'h0, mode_q};
        `REG_EXT:    RDATA_OUT <= {2'h0, ext_q};
        `REG_STATUS: RDATA_OUT <= {10'h000, cur_lo, rd_pend_q, err_q, busy_q}
                                  >> 0;
        `REG_COUNT:  RDATA_OUT <= lock_q;
        `REG_READ:   RDATA_OUT <= {2'h0, (col_q & ~{11'h000, blen}) | {11'h000, cur_lo}};
        default:     RDATA_OUT <= 16'h0000;
      endcase
    end else begin
      RDATA_OUT <= 16'h0000;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_IN && state_q == ST_DLLR && gap_q == 4'h0) begin
      assert (lock_q != 16'h0000) else $error("lock count not armed");
    end
  end

  property bank_sel_p;
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      (!CS_N_OUT && !RAS_N_OUT && !CAS_N_OUT && !WE_N_OUT) |->
        (BA_OUT == `BA_MODE || BA_OUT == `BA_EXT);
  endproperty
  mode_bank_a: assert property (bank_sel_p) else $error("bad bank select");

  op_bits_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (!CS_N_OUT && !RAS_N_OUT && !WE_N_OUT && BA_OUT == `BA_MODE) |->
      (A_OUT[13:9] == 5'h00 && A_OUT[7] == 1'b0))
    else $error("operating mode bits illegal");

  latency_code_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (mode_q[6:4] == `RL_2 || mode_q[6:4] == `RL_2P5 || mode_q == `MODE_RST))
    else $error("illegal latency code held");

  sequence dll_reset_load_s;
    !CS_N_OUT && !RAS_N_OUT && !WE_N_OUT && A_OUT[8];
  endsequence
  dll_follow_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    dll_reset_load_s |-> ##[1:8] (!CS_N_OUT && !RAS_N_OUT && !WE_N_OUT && !A_OUT[8]))
    else $error("no normal load after dll reset");

  sequence ext_load_s;
    !CS_N_OUT && !RAS_N_OUT && !WE_N_OUT && BA_OUT == `BA_EXT;
  endsequence
  ext_then_reset_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    ext_load_s |-> ##[1:8] dll_reset_load_s)
    else $error("no dll reset after ext load");

  dll_enable_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    ext_load_s |-> A_OUT[`EXT_DLL_DIS_BIT] == 1'b0)
    else $error("dll left disabled");

  read_lock_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (!CS_N_OUT && RAS_N_OUT && !CAS_N_OUT && WE_N_OUT) |-> $past(lock_q) == 16'h0000)
    else $error("read before dll lock");

  mrs_gap_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (!CS_N_OUT && !RAS_N_OUT) |=> CS_N_OUT [*2])
    else $error("no gap after mode load");

  interleave_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (rd_pend_q && mode_q[`BT_POS]) |-> cur_lo == (start ^ (word_q & blen)))
    else $error("interleave order wrong");

  // Base-register load on the pins
  sequence base_load_s;
    !CS_N_OUT && !RAS_N_OUT && !CAS_N_OUT && !WE_N_OUT && BA_OUT == `BA_MODE;
  endsequence

  // Extended load slot drives bank code one
  ext_bank_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (state_q == ST_EXT && gap_q == 4'h0) |=> ext_load_s)
    else $error("extended load not issued");

  // Reset and normal slots drive bank code zero
  base_bank_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    ((state_q == ST_DLLR || state_q == ST_NORM) && gap_q == 4'h0) |=> base_load_s)
    else $error("base load not issued");

  // Normal load carries the stored low settings
  norm_fields_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    base_load_s ##0 !A_OUT[`DLL_RST_BIT] |-> (A_OUT[6:0] == mode_q[6:0]))
    else $error("normal load fields wrong");

  // Second sequential word is start plus one, wrapped
  seq_wrap_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (rd_pend_q && !mode_q[`BT_POS] && word_q == 3'h1) |->
      (cur_lo == ((start == blen) ? 3'h0 : (start + 3'h1))))
    else $error("sequential wrap wrong");

  // Lock count armed with the extended load
  lock_arm_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (state_q == ST_EXT && gap_q == 4'h0) |=> (lock_q == `DLL_LOCK_CYC))
    else $error("lock count not loaded");

  // Mode settings held while sequence runs
  mode_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (busy_q && WR_IN && ADDR_IN == `REG_MODE) |=> $stable(mode_q))
    else $error("mode changed while busy");

  // Extended settings held while sequence runs
  ext_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (busy_q && WR_IN && ADDR_IN == `REG_EXT) |=> $stable(ext_q))
    else $error("ext changed while busy");

  // Read column stays within column bits, no auto precharge
  read_col_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (!CS_N_OUT && RAS_N_OUT && !CAS_N_OUT && WE_N_OUT) |->
      (A_OUT[13:12] == 2'h0 && A_OUT[10] == 1'b0))
    else $error("read column out of range");

  // Clock enable stays high out of reset
  cke_high_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    1'b1 |=> CKE_OUT)
    else $error("clock enable dropped");
endmodule

// ---- mrs_ctrl_defs.svh ----
`ifndef MRS_CTRL_DEFS_SVH
`define MRS_CTRL_DEFS_SVH
`define ADDR_W          14
`define REG_CTRL        4'h0
`define REG_MODE        4'h1
`define REG_EXT         4'h2
`define REG_STATUS      4'h3
`define REG_READ        4'h4
`define REG_COUNT       4'h5
`define BL_POS          0
`define BT_POS          3
`define RL_POS          4
`define RL_2            3'h2
`define RL_2P5          3'h6
`define BLC_2           3'h1
`define BLC_4           3'h2
`define BLC_8           3'h3
`define DLL_RST_BIT     8
`define EXT_DLL_DIS_BIT 0
`define BA_MODE         2'h0
`define BA_EXT          2'h1
`define DLL_LOCK_CYC    16'h00C8
`define MRS_GAP_CYC     4'h2
`define MODE_RST        14'h0022
`define EXT_RST         14'h0000
`endif

// ---- mrs_ctrl_pkg.sv ----
package mrs_ctrl_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_EXT   = 6'b000010,
    ST_DLLR  = 6'b000100,
    ST_NORM  = 6'b001000,
    ST_WAIT  = 6'b010000,
    ST_READ  = 6'b100000
  } seq_state_t;
  typedef logic [2:0] rl_code_t;
endpackage

// ---- sdram_mode_model.sv ----
`timescale 1ns/1ps
`include "mrs_ctrl_defs.svh"
module sdram_mode_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        cs_n_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic        cke_in,
  input  wire logic [1:0]  ba_in,
  input  wire logic [13:0] a_in,
  output logic [13:0]      mode_out,
  output logic [13:0]      ext_out,
  output logic [15:0]      reads_out,
  output logic [15:0]      bad_out,
  output logic [2:0]       second_out
);
  logic        lmr, rdc, viol, want_rst_q, want_norm_q, last_lmr_q;
  logic [15:0] lock_q;
  assign lmr = !cs_n_in && !ras_n_in && !cas_n_in && !we_n_in;
  assign rdc = !cs_n_in && ras_n_in && !cas_n_in && we_n_in;
  // Burst word address within the aligned block
  function automatic logic [2:0] word_at(input logic [2:0] s, input logic [2:0] i);
    logic [2:0] m;
    m = (mode_out[2:0] == `BLC_2) ? 3'h1 : (mode_out[2:0] == `BLC_4) ? 3'h3 : 3'h7;
    return mode_out[3] ? ((s ^ i) & m) | (s & ~m) : ((s + i) & m) | (s & ~m);
  endfunction
  always_comb begin
    viol = 1'b0;
    if (lmr && ba_in == `BA_MODE) begin
      viol = ((a_in[13:7] & ~7'h02) != 7'h00) || (a_in[6:4] != `RL_2 && a_in[6:4] != `RL_2P5)
        || a_in[2:0] == 3'h0 || a_in[2:0] > `BLC_8
        || (want_norm_q && a_in[8]) || (want_rst_q && !a_in[8]);
    end else if (lmr && ba_in == `BA_EXT) begin
      viol = a_in[`EXT_DLL_DIS_BIT];
    end else if (lmr) begin
      viol = 1'b1;
    end
    if (rdc && lock_q < `DLL_LOCK_CYC) viol = 1'b1;
    if (last_lmr_q && !cs_n_in) viol = 1'b1;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_out    <= 14'h0000;
      ext_out     <= 14'h0000;
      reads_out   <= 16'h0000;
      bad_out     <= 16'h0000;
      second_out  <= 3'h0;
      lock_q      <= 16'h0000;
      want_rst_q  <= 1'b0;
      want_norm_q <= 1'b0;
      last_lmr_q  <= 1'b0;
    end else begin
      bad_out    <= bad_out + {15'h0000, viol};
      last_lmr_q <= lmr;
      if (cke_in && lock_q != 16'hFFFF) lock_q <= lock_q + 16'h0001;
      if (lmr && ba_in == `BA_MODE) begin
        mode_out    <= a_in & ~(14'h0001 << `DLL_RST_BIT);
        want_rst_q  <= 1'b0;
        want_norm_q <= a_in[8];
      end else if (lmr && ba_in == `BA_EXT) begin
        ext_out     <= a_in;
        lock_q      <= 16'h0000;
        want_rst_q  <= !a_in[`EXT_DLL_DIS_BIT];
      end
      if (rdc) begin
        reads_out  <= reads_out + 16'h0001;
        second_out <= word_at(a_in[2:0], 3'h1);
      end
    end
  end
endmodule

// ---- tb_mrs_ctrl.sv ----
`timescale 1ns/1ps
`include "mrs_ctrl_defs.svh"
module tb_mrs_ctrl;
  logic        clk, rst, wr, rd, cs_n, ras_n, cas_n, we_n, cke;
  logic [3:0]  addr;
  logic [1:0]  ba;
  logic [13:0] a, mode, ext;
  logic [2:0]  second;
  logic [15:0] wdata, rdata, v, reads, bad;
  logic [15:0] good [3] = '{16'h0021, 16'h006A, 16'h002B};
  logic [15:0] evil [2] = '{16'h0032, 16'h0024};
  int          n_fail, total_checks, i;
  mrs_ctrl dut (.CLK_SYS_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CS_N_OUT(cs_n), .RAS_N_OUT(ras_n),
    .CAS_N_OUT(cas_n), .WE_N_OUT(we_n), .CKE_OUT(cke), .BA_OUT(ba), .A_OUT(a));
  sdram_mode_model dev (.clk_in(clk), .rst_in(rst), .cs_n_in(cs_n), .ras_n_in(ras_n),
    .cas_n_in(cas_n), .we_n_in(we_n), .cke_in(cke), .ba_in(ba), .a_in(a), .mode_out(mode),
    .ext_out(ext), .reads_out(reads), .bad_out(bad), .second_out(second));
  task automatic wr_reg(input logic [3:0] ad, input logic [15:0] d);
    @(posedge clk);
    addr  <= ad;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] ad, output logic [15:0] d);
    @(posedge clk);
    addr <= ad;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 100; k++) begin
      rd_reg(`REG_STATUS, v);
      if (v[0] === 1'b0) break;
    end
    chk(v & 16'h0001, 16'h0000);
  endtask
  task automatic stop_test();
    $display("Mismatches %0d of %0d comparisons", n_fail, total_checks);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #50000;
    n_fail++;
    stop_test();
  end
  initial begin
    rst          = 1'b1;
    wr           = 1'b0;
    rd           = 1'b0;
    addr         = 4'h0;
    wdata        = 16'h0000;
    n_fail       = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`REG_MODE, v);
    chk(v, 16'h0022);
    rd_reg(`REG_EXT, v);
    chk(v, 16'h0000);
    for (i = 0; i < 3; i++) begin
      wr_reg(`REG_MODE, good[i]);
      rd_reg(`REG_MODE, v);
      chk(v, good[i]);
      wr_reg(`REG_CTRL, 16'h0001);
      @(posedge clk);
      wr_reg(`REG_MODE, 16'h0023);
      wait_idle();
      rd_reg(`REG_MODE, v);
      chk(v, good[i]);
      chk({2'h0, mode}, good[i]);
      chk({15'h0000, ext[`EXT_DLL_DIS_BIT]}, 16'h0000);
    end
    wr_reg(`REG_READ, 16'h0005);
    repeat (5) @(posedge clk);
    #1;
    chk(reads, 16'h0000);
    repeat (210) @(posedge clk);
    rd_reg(`REG_COUNT, v);
    chk(v, 16'h0000);
    wr_reg(`REG_READ, 16'h0005);
    repeat (10) @(posedge clk);
    #1;
    chk(reads, 16'h0001);
    chk({13'h0000, second}, 16'h0004);
    wr_reg(`REG_MODE, 16'h0023);
    wr_reg(`REG_CTRL, 16'h0001);
    wait_idle();
    repeat (210) @(posedge clk);
    wr_reg(`REG_READ, 16'h0007);
    repeat (10) @(posedge clk);
    #1;
    chk(reads, 16'h0002);
    chk({13'h0000, second}, 16'h0000);
    for (i = 0; i < 2; i++) begin
      wr_reg(`REG_MODE, evil[i]);
      rd_reg(`REG_STATUS, v);
      chk(v & 16'h0002, 16'h0002);
      wr_reg(`REG_STATUS, 16'h0000);
      rd_reg(`REG_MODE, v);
      chk(v, 16'h0023);
    end
    rd_reg(`REG_STATUS, v);
    chk(v & 16'h0002, 16'h0000);
    chk(bad, 16'h0000);
    stop_test();
  end
endmodule
